//--- hdl/sfcp_cfg.svh
// opcodes, field positions and counts of the serial flash command port
`ifndef SFCP_CFG_SVH
`define SFCP_CFG_SVH

// command opcodes
`define SFCP_OP_READ    8'h03
`define SFCP_OP_FREAD   8'h0B
`define SFCP_OP_SSE_A   8'hD7
`define SFCP_OP_SSE_B   8'h20
`define SFCP_OP_SE      8'hD8
`define SFCP_OP_CE      8'hC7
`define SFCP_OP_PP      8'h02
`define SFCP_OP_WREN    8'h06
`define SFCP_OP_WRDI    8'h04
`define SFCP_OP_PDOWN   8'hB9
`define SFCP_OP_RDSR    8'h05
`define SFCP_OP_WRSR    8'h01
`define SFCP_OP_RDID    8'h9F
`define SFCP_OP_RES     8'hAB

// framing
`define SFCP_BIT_TOP    3'h7
`define SFCP_BIT_ZERO   3'h0
`define SFCP_BIT_ONE    3'h1
`define SFCP_CNT_ZERO   2'h0
`define SFCP_CNT_ONE    2'h1
`define SFCP_ADDR_LAST  2'h2
`define SFCP_FDUM_LAST  2'h0
`define SFCP_IDUM_LAST  2'h2

// decoded address width, upper address bits are dropped
`define SFCP_ADDR_W     18
`define SFCP_ADDR_ONE   18'h00001

// status byte fields
`define SFCP_SR_WEN_BIT  1
`define SFCP_SR_LOCK_BIT 7

`endif

//--- hdl/sfcp_cmd_port.sv
// serial flash command port: pin sampling, opcode decode and command hand-off
`timescale 1ns/1ps
`include "sfcp_cfg.svh"
module sfcp_cmd_port
   import sfcp_pkg::*;
#(
   parameter logic [7:0] ID_MAKER = 8'h5A,  // arbitrary value
   parameter logic [7:0] ID_PART  = 8'h3C   // arbitrary value
) (
   input  wire logic                     core_clk,
   input  wire logic                     srst,
   input  wire logic                     sck,
   input  wire logic                     cs_n,
   input  wire logic                     si,
   input  wire logic                     wp_n,
   input  wire logic                     hold_n,
   input  wire logic [7:0]               rd_data,
   input  wire logic [7:0]               status_in,
   output logic                          so,
   output logic                          so_oe,
   output logic                          spi_mode3,
   output logic                          power_down,
   output logic [`SFCP_ADDR_W-1:0]       rd_addr,
   output logic [`SFCP_ADDR_W-1:0]       op_addr,
   output logic                          wren_pulse,
   output logic                          wrdis_pulse,
   output logic                          small_erase_req,
   output logic                          sector_erase_req,
   output logic                          chip_erase_req,
   output logic                          pgm_byte_valid,
   output logic [7:0]                    page_write_data,
   output logic                          pgm_commit,
   output logic                          stat_wr_req,
   output logic [7:0]                    stat_wr_data
);

   // synchronised pins, with one-cycle-old copies of the clock and select only
   logic sck_s;
   logic sck_p;
   logic cs_n_s;
   logic cs_n_p;
   logic si_s;
   logic wp_n_s;
   logic hold_n_s;

   sfcp_sync #(.RST_VAL(1'b0)) u_sync_sck (
      .core_clk (core_clk),
      .srst     (srst),
      .d        (sck),
      .q        (sck_s),
      .q_prev   (sck_p)
   );

   sfcp_sync #(.RST_VAL(1'b1)) u_sync_cs (
      .core_clk (core_clk),
      .srst     (srst),
      .d        (cs_n),
      .q        (cs_n_s),
      .q_prev   (cs_n_p)
   );

   sfcp_sync #(.RST_VAL(1'b0)) u_sync_si (
      .core_clk (core_clk),
      .srst     (srst),
      .d        (si),
      .q        (si_s),
      .q_prev   ()
   );

   sfcp_sync #(.RST_VAL(1'b1)) u_sync_wp (
      .core_clk (core_clk),
      .srst     (srst),
      .d        (wp_n),
      .q        (wp_n_s),
      .q_prev   ()
   );

   sfcp_sync #(.RST_VAL(1'b1)) u_sync_hold (
      .core_clk (core_clk),
      .srst     (srst),
      .d        (hold_n),
      .q        (hold_n_s),
      .q_prev   ()
   );

   sfcp_state_t                 state_r;
   sfcp_state_t                 state_nxt;
   logic [7:0]                  op_r;
   logic [7:0]                  in_sh_r;
   logic [7:0]                  byte_in;
   logic [2:0]                  bit_cnt_r;
   logic [1:0]                  byte_cnt_r;
   logic [`SFCP_ADDR_W-1:0]     addr_r;
   logic [2:0]                  obit_r;
   logic                        out_busy_r;
   logic                        id_sel_r;
   logic                        pgm_seen_r;
   logic [7:0]                  out_src;
   logic                        active;
   logic                        sck_rise;
   logic                        sck_fall;
   logic                        cs_fall;
   logic                        cs_rise;
   logic                        byte_done;
   logic                        end_ok;
   logic                        act_wait;
   logic                        out_load;
   logic                        out_shift;
   logic                        stat_wr_ok;

   // clock edges count only while selected and not held
   assign active   = !cs_n_s && hold_n_s;
   assign sck_rise = active && sck_s && !sck_p;
   assign sck_fall = active && !sck_s && sck_p;
   assign cs_fall  = !cs_n_s && cs_n_p;
   assign cs_rise  = cs_n_s && !cs_n_p;
   assign byte_in  = {in_sh_r[6:0], si_s};
   assign byte_done = sck_rise && (bit_cnt_r == `SFCP_BIT_ZERO);

   // a command counts only if select rises on a byte boundary
   assign end_ok   = cs_rise && (bit_cnt_r == `SFCP_BIT_TOP);
   assign act_wait = end_ok && (state_r == sfcp_st_wait_cs);

   // lock bit blocks a status write only while write-protect is low
   assign stat_wr_ok = status_in[`SFCP_SR_WEN_BIT] &&
                       !(status_in[`SFCP_SR_LOCK_BIT] && !wp_n_s);

   // state after the opcode byte
   function automatic sfcp_state_t op_next(input logic [7:0] op, input logic asleep);
      sfcp_state_t nx;
      nx = sfcp_st_ignore;
      if (asleep && (op != `SFCP_OP_RES)) begin
         nx = sfcp_st_ignore;
      end else begin
         case (op)
            `SFCP_OP_READ, `SFCP_OP_FREAD,
            `SFCP_OP_SSE_A, `SFCP_OP_SSE_B, `SFCP_OP_SE,
            `SFCP_OP_PP:   nx = sfcp_st_addr;
            `SFCP_OP_CE, `SFCP_OP_WREN, `SFCP_OP_WRDI,
            `SFCP_OP_PDOWN: nx = sfcp_st_wait_cs;
            `SFCP_OP_WRSR: nx = sfcp_st_data_in;
            `SFCP_OP_RDSR, `SFCP_OP_RDID: nx = sfcp_st_out;
            `SFCP_OP_RES:  nx = sfcp_st_dummy;
            default:       nx = sfcp_st_ignore;
         endcase
      end
      return nx;
   endfunction

   // frame sequencing; ignore swallows everything until select rises
   always_comb begin
      state_nxt = state_r;
      if (cs_n_s) begin
         state_nxt = sfcp_st_idle;
      end else if (cs_fall) begin
         state_nxt = sfcp_st_opcode;
      end else if ((state_r == sfcp_st_wait_cs) && sck_rise) begin
         state_nxt = sfcp_st_ignore;
      end else if (byte_done) begin
         case (state_r)
            sfcp_st_opcode: begin
               state_nxt = op_next(byte_in, power_down);
            end
            sfcp_st_addr: begin
               if (byte_cnt_r == `SFCP_ADDR_LAST) begin
                  case (op_r)
                     `SFCP_OP_READ:  state_nxt = sfcp_st_out;
                     `SFCP_OP_FREAD: state_nxt = sfcp_st_dummy;
                     `SFCP_OP_PP:    state_nxt = sfcp_st_data_in;
                     default:        state_nxt = sfcp_st_wait_cs;
                  endcase
               end
            end
            sfcp_st_dummy: begin
               if ((op_r == `SFCP_OP_FREAD) && (byte_cnt_r == `SFCP_FDUM_LAST)) begin
                  state_nxt = sfcp_st_out;
               end else if (byte_cnt_r == `SFCP_IDUM_LAST) begin
                  state_nxt = sfcp_st_out;
               end
            end
            sfcp_st_data_in: begin
               if (op_r == `SFCP_OP_WRSR) begin
                  state_nxt = sfcp_st_wait_cs;
               end
            end
            default: state_nxt = state_r;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_r <= sfcp_st_idle;
      end else begin
         state_r <= state_nxt;
      end
   end

   // input shifter and bit counter, restarted by every select fall
   always_ff @(posedge core_clk) begin
      if (srst || cs_fall) begin
         in_sh_r   <= '0;
         bit_cnt_r <= `SFCP_BIT_TOP;
      end else if (sck_rise) begin
         in_sh_r   <= byte_in;
         bit_cnt_r <= bit_cnt_r - `SFCP_BIT_ONE;                       // wraps to 7
      end
   end

   // byte counter within the current phase
   always_ff @(posedge core_clk) begin
      if (srst || (state_nxt != state_r)) begin
         byte_cnt_r <= `SFCP_CNT_ZERO;
      end else if (byte_done) begin
         byte_cnt_r <= byte_cnt_r + `SFCP_CNT_ONE;
      end
   end

   // opcode and address capture; high address bits fall off the top
   always_ff @(posedge core_clk) begin
      if (srst) begin
         op_r   <= '0;
         addr_r <= '0;
      end else if (byte_done && (state_r == sfcp_st_opcode)) begin
         op_r   <= byte_in;
      end else if (byte_done && (state_r == sfcp_st_addr)) begin
         addr_r <= {addr_r[`SFCP_ADDR_W-9:0], byte_in};
      end
   end

   // clock level at the select fall tells mode 3 from mode 0
   always_ff @(posedge core_clk) begin
      if (srst) begin
         spi_mode3 <= 1'b0;
      end else if (cs_fall) begin
         spi_mode3 <= sck_s;
      end
   end

   // received data bytes: page data streams out, status byte is held
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pgm_byte_valid  <= 1'b0;
         page_write_data <= '0;
         stat_wr_data    <= '0;
         pgm_seen_r      <= 1'b0;
      end else begin
         pgm_byte_valid <= byte_done && (state_r == sfcp_st_data_in) &&
                           (op_r == `SFCP_OP_PP);
         if (cs_fall) begin
            pgm_seen_r <= 1'b0;
         end else if (byte_done && (state_r == sfcp_st_data_in)) begin
            if (op_r == `SFCP_OP_PP) begin
               page_write_data <= byte_in;
               pgm_seen_r      <= 1'b1;
            end else begin
               stat_wr_data    <= byte_in;
            end
         end
      end
   end

   // command hand-off pulses, issued only at a clean select rise
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wren_pulse       <= 1'b0;
         wrdis_pulse      <= 1'b0;
         small_erase_req  <= 1'b0;
         sector_erase_req <= 1'b0;
         chip_erase_req   <= 1'b0;
         stat_wr_req      <= 1'b0;
         pgm_commit       <= 1'b0;
         op_addr          <= '0;
      end else begin
         wren_pulse       <= act_wait && (op_r == `SFCP_OP_WREN);
         wrdis_pulse      <= act_wait && (op_r == `SFCP_OP_WRDI);
         small_erase_req  <= act_wait && ((op_r == `SFCP_OP_SSE_A) ||
                                          (op_r == `SFCP_OP_SSE_B));
         sector_erase_req <= act_wait && (op_r == `SFCP_OP_SE);
         chip_erase_req   <= act_wait && (op_r == `SFCP_OP_CE);
         stat_wr_req      <= act_wait && (op_r == `SFCP_OP_WRSR) &&
                             stat_wr_ok;
         pgm_commit       <= end_ok && (state_r == sfcp_st_data_in) &&
                             (op_r == `SFCP_OP_PP) && pgm_seen_r;
         if (cs_rise) begin
            op_addr <= addr_r;
         end
      end
   end

   // power-down entry on B9h, exit on a lone ABh closed by select rise
   always_ff @(posedge core_clk) begin
      if (srst) begin
         power_down <= 1'b0;
      end else if (act_wait && (op_r == `SFCP_OP_PDOWN)) begin
         power_down <= 1'b1;
      end else if (end_ok && (state_r == sfcp_st_dummy) && (op_r == `SFCP_OP_RES) &&
                   (byte_cnt_r == `SFCP_CNT_ZERO)) begin
         power_down <= 1'b0;
      end
   end

   // source of each outgoing byte
   always_comb begin
      case (op_r)
         `SFCP_OP_READ, `SFCP_OP_FREAD: out_src = rd_data;
         `SFCP_OP_RDSR: out_src = status_in;
         `SFCP_OP_RDID: out_src = id_sel_r ? ID_PART : ID_MAKER;
         `SFCP_OP_RES:  out_src = ID_PART;
         default:       out_src = '0;
      endcase
   end

   assign out_load  = sck_fall && (state_r == sfcp_st_out) && (obit_r == `SFCP_BIT_ZERO);
   assign out_shift = sck_fall && (state_r == sfcp_st_out) && (obit_r != `SFCP_BIT_ZERO);

   // output bit position, id byte toggle and first-byte marker
   always_ff @(posedge core_clk) begin
      if (srst || cs_fall) begin
         obit_r     <= `SFCP_BIT_ZERO;
         out_busy_r <= 1'b0;
         id_sel_r   <= 1'b0;
      end else if (sck_fall && (state_r == sfcp_st_out)) begin
         obit_r     <= obit_r + `SFCP_BIT_ONE;
         out_busy_r <= 1'b1;
         if (out_load) begin
            id_sel_r <= !id_sel_r;
         end
      end
   end

   // read address: latched before the first byte, bumped per byte, wraps
   // on its own width; memory gets at least three cycles to answer
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rd_addr <= '0;
      end else if (out_load) begin
         rd_addr <= rd_addr + `SFCP_ADDR_ONE;
      end else if (!out_busy_r) begin
         rd_addr <= addr_r;
      end
   end

   sfcp_out_shift u_out_shift (
      .core_clk (core_clk),
      .srst     (srst),
      .load     (out_load),
      .shift    (out_shift),
      .din      (out_src),
      .so       (so)
   );

   // pin driven only once data flows; released while held or deselected
   always_ff @(posedge core_clk) begin
      if (srst) begin
         so_oe <= 1'b0;
      end else begin
         so_oe <= (state_r == sfcp_st_out) && (out_busy_r || out_load) &&
                  hold_n_s && !cs_n_s;
      end
   end

endmodule

//--- hdl/sfcp_out_shift.sv
// parallel-load, msb-first serialiser behind the serial output pin
`timescale 1ns/1ps
module sfcp_out_shift (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic       load,
   input  wire logic       shift,
   input  wire logic [7:0] din,
   output logic            so
);

   logic [6:0] rest_r;

   // load puts bit 7 on the pin at once; each shift brings the next bit
   always_ff @(posedge core_clk) begin
      if (srst) begin
         so     <= 1'b0;
         rest_r <= '0;
      end else if (load) begin
         {so, rest_r} <= din;
      end else if (shift) begin
         {so, rest_r} <= {rest_r, 1'b0};
      end
   end

endmodule

//--- hdl/sfcp_pkg.sv
// types shared by the serial flash command port
package sfcp_pkg;

   typedef enum logic [2:0] {
      sfcp_st_idle    = 3'b000,
      sfcp_st_opcode  = 3'b001,
      sfcp_st_addr    = 3'b010,
      sfcp_st_dummy   = 3'b011,
      sfcp_st_data_in = 3'b100,
      sfcp_st_out     = 3'b101,
      sfcp_st_wait_cs = 3'b110,
      sfcp_st_ignore  = 3'b111
   } sfcp_state_t;

endpackage

//--- hdl/sfcp_sync.sv
// two-flop synchroniser for one pin, with a delayed copy for edge finding
`timescale 1ns/1ps
module sfcp_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic d,
   output logic      q,
   output logic      q_prev
);

   logic meta_r;

   // the first flop feeds only the second one
   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_r <= RST_VAL;
         q      <= RST_VAL;
         q_prev <= RST_VAL;
      end else begin
         meta_r <= d;
         q      <= meta_r;
         q_prev <= q;
      end
   end

endmodule

//--- verification/serial_flash_command_port_bench.sv
// self-checking bench for the serial flash command port
`timescale 1ns/1ps
`include "sfcp_cfg.svh"
module serial_flash_command_port_bench;
   localparam logic [7:0] ID_A = 8'hA1;  // arbitrary value
   localparam logic [7:0] ID_B = 8'h4E;  // arbitrary value
   logic        core_clk, srst, sck, cs_n, si, wp_n, hold_n, so, so_oe, spi_mode3;
   logic        power_down, wren_pulse, wrdis_pulse, small_erase_req, sector_erase_req;
   logic        chip_erase_req, pgm_byte_valid, pgm_commit, stat_wr_req;
   logic [7:0]  rd_data, status_in, page_write_data, stat_wr_data, b, d, e;
   logic [17:0] rd_addr, op_addr;
   logic [23:0] addr;
   logic [6:0]  pv;
   logic [7:0]  txq[$], rxq[$], pgq[$];
   int          cnt[7], exp_cnt[7], error_cnt, comparisons, cyc;
   logic [7:0]  ops[6] = '{`SFCP_OP_WREN, `SFCP_OP_WRDI, `SFCP_OP_SSE_A, `SFCP_OP_SSE_B,
                           `SFCP_OP_SE, `SFCP_OP_CE};
   int          pidx[6] = '{0, 1, 2, 2, 3, 4};
   logic [7:0]  st_tab[4] = '{8'h82, 8'h82, 8'h02, 8'h80};
   logic [3:0]  acc_tab = 4'b0110;

   // array contents as a function of address, low bits mixed with high ones
   function automatic logic [7:0] mem(input logic [17:0] a);
      return a[7:0] ^ {a[17:12], 2'h0} ^ 8'h96;
   endfunction
   assign rd_data = mem(rd_addr);
   assign pv = {pgm_commit, stat_wr_req, chip_erase_req, sector_erase_req,
                small_erase_req, wrdis_pulse, wren_pulse};

   sfcp_cmd_port #(.ID_MAKER(ID_A), .ID_PART(ID_B)) sfcp_cmd_port_i (
      .core_clk(core_clk), .srst(srst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
      .hold_n(hold_n), .rd_data(rd_data), .status_in(status_in), .so(so), .so_oe(so_oe),
      .spi_mode3(spi_mode3), .power_down(power_down), .rd_addr(rd_addr),
      .op_addr(op_addr), .wren_pulse(wren_pulse), .wrdis_pulse(wrdis_pulse),
      .small_erase_req(small_erase_req), .sector_erase_req(sector_erase_req),
      .chip_erase_req(chip_erase_req), .pgm_byte_valid(pgm_byte_valid),
      .page_write_data(page_write_data), .pgm_commit(pgm_commit),
      .stat_wr_req(stat_wr_req), .stat_wr_data(stat_wr_data));
   sfcp_host_model sfcp_host_model_i (
      .core_clk(core_clk), .so(so), .so_oe(so_oe), .sck(sck), .cs_n(cs_n), .si(si),
      .hold_n(hold_n));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // pulse counts and page bytes seen; cycle ceiling cuts a hang short
   // sampled on the falling edge, where the registered outputs have settled
   always @(negedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         stop_test();
      end
      foreach (cnt[j]) cnt[j] += int'(pv[j] === 1'b1);
      if (pgm_byte_valid === 1'b1) pgq.push_back(page_write_data);
   end
   task automatic stop_test();
      if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_cnt();
      foreach (cnt[j]) chk("pulse count", 18'(exp_cnt[j]), 18'(cnt[j]));
   endtask
   // send txq whole, then collect nrx reply bytes, with an optional hold between them
   task automatic frame(input logic m3, input int nrx, input logic hold_mid);
      logic [7:0] r;
      rxq = {};
      sfcp_host_model_i.start(m3);
      foreach (txq[k]) sfcp_host_model_i.xfer(txq[k], 8, r);
      for (int k = 0; k < nrx; k++) begin
         if (hold_mid && k == 1) sfcp_host_model_i.pause();
         sfcp_host_model_i.xfer(8'($urandom), 8, r);
         rxq.push_back(r);
      end
      sfcp_host_model_i.finish();
   endtask

   initial begin
      void'($urandom(32'h99d9));
      srst = 1'b1;
      wp_n = 1'b1;
      status_in = 8'h00;
      repeat (10) @(negedge core_clk);
      srst = 1'b0;
      repeat (4) @(negedge core_clk);
      // single byte and erase commands in both clock modes
      for (int i = 0; i < 6; i++) begin
         addr = 24'($urandom);
         txq = {ops[i]};
         if (i >= 2 && i <= 4) txq = {ops[i], addr[23:16], addr[15:8], addr[7:0]};
         frame(i[0], 0, 1'b0);
         exp_cnt[pidx[i]]++;
         check_cnt();
         chk("mode", 18'(i[0]), 18'(spi_mode3));
         if (txq.size() > 1) chk("op_addr", addr[17:0], op_addr);
      end
      // cut byte, unknown opcode, erase short of address: no effect
      sfcp_host_model_i.start(1'b0);
      sfcp_host_model_i.xfer(`SFCP_OP_WREN, 5, b);
      sfcp_host_model_i.finish();
      txq = {8'hFF, `SFCP_OP_WREN};
      frame(1'b0, 0, 1'b0);
      txq = {`SFCP_OP_SE, 8'h12, 8'h34};
      frame(1'b1, 0, 1'b0);
      check_cnt();
      // status write against lock, write-protect pin and write enable
      for (int i = 0; i < 4; i++) begin
         wp_n = i[0];
         status_in = st_tab[i];
         d = 8'($urandom);
         txq = {`SFCP_OP_WRSR, d};
         frame(1'b0, 0, 1'b0);
         exp_cnt[5] += int'(acc_tab[i]);
         check_cnt();
         if (acc_tab[i]) chk("stat_wr_data", 18'(d), 18'(stat_wr_data));
      end
      wp_n = 1'b1;
      // status read repeats across a hold
      status_in = 8'($urandom);
      txq = {`SFCP_OP_RDSR};
      frame(1'b1, 3, 1'b1);
      foreach (rxq[k]) chk("status byte", 18'(status_in), 18'(rxq[k]));
      // array read across the top address, then fast read
      addr = {6'($urandom), 18'h3FFFF};
      txq = {`SFCP_OP_READ, addr[23:16], addr[15:8], addr[7:0]};
      frame(1'b0, 2, 1'b0);
      chk("read top", 18'(mem(18'h3FFFF)), 18'(rxq[0]));
      chk("read wrap", 18'(mem(18'h00000)), 18'(rxq[1]));
      addr = 24'($urandom);
      txq = {`SFCP_OP_FREAD, addr[23:16], addr[15:8], addr[7:0], 8'($urandom)};
      frame(1'b1, 2, 1'b0);
      chk("fast read", 18'(mem(addr[17:0])), 18'(rxq[0]));
      chk("fast next", 18'(mem(addr[17:0] + 18'h00001)), 18'(rxq[1]));
      // identification in both forms
      txq = {`SFCP_OP_RDID};
      frame(1'b0, 2, 1'b0);
      chk("id first", 18'(ID_A), 18'(rxq[0]));
      chk("id second", 18'(ID_B), 18'(rxq[1]));
      txq = {`SFCP_OP_RES, 8'h00, 8'h00, 8'h00};
      frame(1'b1, 1, 1'b0);
      chk("id short", 18'(ID_B), 18'(rxq[0]));
      // power down refuses commands until the lone release byte
      txq = {`SFCP_OP_PDOWN};
      frame(1'b0, 0, 1'b0);
      chk("power_down", 18'h00001, 18'(power_down));
      txq = {`SFCP_OP_WREN};
      frame(1'b0, 0, 1'b0);
      check_cnt();
      txq = {`SFCP_OP_RES};
      frame(1'b1, 0, 1'b0);
      chk("power_down", 18'h00000, 18'(power_down));
      // page program with two data bytes
      addr = 24'($urandom);
      d = 8'($urandom);
      e = 8'($urandom);
      pgq = {};
      txq = {`SFCP_OP_PP, addr[23:16], addr[15:8], addr[7:0], d, e};
      frame(1'b0, 0, 1'b0);
      exp_cnt[6]++;
      check_cnt();
      chk("page bytes", 18'h00002, 18'(pgq.size()));
      chk("page byte 0", 18'(d), 18'(pgq[0]));
      chk("page byte 1", 18'(e), 18'(pgq[1]));
      chk("op_addr", addr[17:0], op_addr);
      stop_test();
   end
endmodule

bind sfcp_cmd_port sfcp_cmd_port_sva sfcp_cmd_port_sva_i (
   .core_clk(core_clk), .srst(srst), .sck(sck), .cs_n(cs_n), .wp_n(wp_n), .hold_n(hold_n),
   .status_in(status_in), .so(so), .so_oe(so_oe), .spi_mode3(spi_mode3),
   .wren_pulse(wren_pulse), .wrdis_pulse(wrdis_pulse), .small_erase_req(small_erase_req),
   .sector_erase_req(sector_erase_req), .chip_erase_req(chip_erase_req),
   .pgm_byte_valid(pgm_byte_valid), .pgm_commit(pgm_commit), .stat_wr_req(stat_wr_req));

//--- verification/sfcp_cmd_port_sva.sv
// assertion checker for the serial flash command port pins
`timescale 1ns/1ps
module sfcp_cmd_port_sva (
   input wire logic       core_clk,
   input wire logic       srst,
   input wire logic       sck,
   input wire logic       cs_n,
   input wire logic       wp_n,
   input wire logic       hold_n,
   input wire logic [7:0] status_in,
   input wire logic       so,
   input wire logic       so_oe,
   input wire logic       spi_mode3,
   input wire logic       wren_pulse,
   input wire logic       wrdis_pulse,
   input wire logic       small_erase_req,
   input wire logic       sector_erase_req,
   input wire logic       chip_erase_req,
   input wire logic       pgm_byte_valid,
   input wire logic       pgm_commit,
   input wire logic       stat_wr_req
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   // command pulses gathered so one property covers all of them
   logic [6:0] cmd_v;
   assign cmd_v = {wren_pulse, wrdis_pulse, small_erase_req, sector_erase_req,
                   chip_erase_req, stat_wr_req, pgm_commit};
   // pin levels held long enough to pass the synchronisers
   sequence s_deselected;
      cs_n [*6];
   endsequence
   sequence s_held;
      !hold_n [*6];
   endsequence
   property p_oe_deselect;
      s_deselected |-> !so_oe;
   endproperty
   a_oe_deselect: assert property (p_oe_deselect)
      else $error("output enabled while deselected");
   property p_hold_quiet;
      s_held |-> !so_oe;
   endproperty
   a_hold_quiet: assert property (p_hold_quiet)
      else $error("output enabled during hold");
   property p_cmd_at_rise;
      |cmd_v |-> cs_n && $past(cs_n, 2);
   endproperty
   a_cmd_at_rise: assert property (p_cmd_at_rise)
      else $error("command acted on before select rise");
   property p_cmd_onehot;
      $onehot0(cmd_v);
   endproperty
   a_cmd_onehot: assert property (p_cmd_onehot)
      else $error("two command pulses at once");
   // a page byte needs eight serial clocks, each at least two core cycles
   property p_pgm_gap;
      pgm_byte_valid |-> !cs_n ##1 !pgm_byte_valid [*8];
   endproperty
   a_pgm_gap: assert property (p_pgm_gap)
      else $error("page byte pulse out of frame or too close");
   property p_mode_pick;
      $fell(cs_n) && $stable(sck) |-> ##5 (spi_mode3 == $past(sck, 5));
   endproperty
   a_mode_pick: assert property (p_mode_pick)
      else $error("clock mode not taken at select fall");
   // so may only move a few cycles after a serial clock fall
   property p_so_on_fall;
      $changed(so) && so_oe && $past(so_oe) && !$past(cs_n, 4) && $past(hold_n, 4)
         |-> !$past(sck, 3);
   endproperty
   a_so_on_fall: assert property (p_so_on_fall)
      else $error("serial output changed away from a clock fall");
   property p_stat_gate;
      stat_wr_req |-> status_in[1] && (!status_in[7] || $past(wp_n, 3));
   endproperty
   a_stat_gate: assert property (p_stat_gate)
      else $error("status write taken while locked or not enabled");
endmodule

//--- verification/sfcp_host_model.sv
// host spi controller model driving the command port pins
`timescale 1ns/1ps
module sfcp_host_model (
   input  wire logic core_clk,
   input  wire logic so,
   input  wire logic so_oe,
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   output logic      hold_n
);
   // idle: deselected, hold released
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      hold_n = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // park the clock at the mode level before selecting
   task automatic start(input logic m3);
      sck = m3;
      wait_clk(8);
      cs_n = 1'b0;
      wait_clk(6);
   endtask
   // bits msb first; so is read late in the high phase, where it has settled
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < nbits; i++) begin
         sck = 1'b0;
         si = tx[7-i];
         wait_clk(4);
         sck = 1'b1;
         wait_clk(4);
         rx[7-i] = so_oe ? so : 1'bz;
      end
   endtask
   // select rises after the last bit sent, whole byte or not; si is left toggled so no stale level lingers
   task automatic finish();
      wait_clk(4);
      cs_n = 1'b1;
      si = ~si;
      wait_clk(8);
   endtask
   // clock edges during hold must be ignored; level restored before release
   task automatic pause();
      hold_n = 1'b0;
      wait_clk(4);
      repeat (2) begin
         sck = ~sck;
         wait_clk(4);
      end
      hold_n = 1'b1;
      wait_clk(4);
   endtask
endmodule
